/* File: src/loop_sequencer.sv */
// operation-entry sequencer with counted loops and per-pass position offset
//
// How it works
// - repeat span from count entry to end marker
// - after last pass follow end entry's next field
// - entry with no link halts the sequence
// - link codes none, manual, automatic, continuous
// - next codes stop, plus two, plus one, absolute
// - loop count zero means no loop
// - signed 23-bit offset in steps per entry
// - end flag marks the closing entry
// - absolute entries offset the target coordinate
// - incremental entries offset the travel distance
// - offset accumulates once more each pass
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
module loop_sequencer
   import loop_seq_pkg::*;
#(
   parameter int DEPTH = 256,
   parameter int AW    = 8
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_b_i,
   input  wire logic             ce_i,
   input  wire logic [7:0]       addr_i,
   input  wire logic [31:0]      wr_data_i,
   input  wire logic             wr_i,
   input  wire logic             rd_i,
   output logic      [31:0]      rd_data_o,
   input  wire logic             move_done_i,
   output logic                  move_valid_o,
   output logic      [POS_W-1:0] move_target_o,
   output logic                  move_incr_o,
   output logic      [AW-1:0]    move_entry_o,
   output logic                  busy_o
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      seq_state_t        state;
      logic [AW-1:0]     cur_idx;
      logic              loop_active;
      logic [AW-1:0]     loop_start;
      logic [COUNT_W-1:0] loop_total;
      logic [COUNT_W-1:0] loop_pass;
      logic [LINK_W-1:0] ent_link;
      logic [NEXT_W-1:0] ent_next;
      logic              ent_end;
      logic              move_valid;
      logic [POS_W-1:0]  move_target;
      logic              move_incr;
      logic              busy;
      logic [31:0]       rd_data;
      logic [AW-1:0]     entry_sel;
      logic [POS_W-1:0]  stg_pos;
      logic [CFG_W-1:0]  stg_cfg;
      logic [OFS_W-1:0]  stg_ofs;
   } seq_regs_t;

   seq_regs_t r_reg;
   seq_regs_t r_next;

   // ---------------------------------------------------------------
   // entry table
   // ---------------------------------------------------------------
   logic               mem_we;
   logic               mem_re;
   logic [ENTRY_W-1:0] mem_q;

   assign mem_we = wr_i && (addr_i == COMMIT_ADDR);
   assign mem_re = (r_reg.state == S_FETCH);

   loop_table_mem #(
      .WIDTH (ENTRY_W),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_table (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .ce_i      (ce_i),
      .wr_en_i   (mem_we),
      .wr_addr_i (r_reg.entry_sel),
      .wr_data_i ({r_reg.stg_pos, r_reg.stg_cfg, r_reg.stg_ofs}),
      .rd_en_i   (mem_re),
      .rd_addr_i (r_reg.cur_idx),
      .rd_data_o (mem_q)
   );

   // fields of the entry just read
   logic [POS_W-1:0]   ent_pos;
   logic [CFG_W-1:0]   ent_cfg;
   logic [OFS_W-1:0]   ent_ofs;
   logic [COUNT_W-1:0] ent_count;
   logic signed [POS_W-1:0] loop_shift;

   assign {ent_pos, ent_cfg, ent_ofs} = mem_q;
   assign ent_count = ent_cfg[CFG_COUNT_LSB +: COUNT_W];
   // pass number times offset, so each pass adds one more offset
   assign loop_shift = POS_W'($signed({1'b0, r_reg.loop_pass}))
                     * POS_W'($signed(ent_ofs));

   // ---------------------------------------------------------------
   // bus strobes decoded
   // ---------------------------------------------------------------
   logic start_req;
   logic stop_req;
   logic cont_req;
   logic ctrl_wr;

   assign ctrl_wr   = wr_i && (addr_i == CTRL_ADDR);
   assign start_req = ctrl_wr && wr_data_i[CTRL_START_BIT];
   assign stop_req  = ctrl_wr && wr_data_i[CTRL_STOP_BIT];
   assign cont_req  = ctrl_wr && wr_data_i[CTRL_CONT_BIT];

   // decision after a finished move
   logic          rewind;
   logic          next_ok;
   logic [AW:0]   next_idx;
   logic          end_hit;

   // end marker only closes a loop that is running
   assign end_hit = r_reg.loop_active && r_reg.ent_end;
   assign rewind  = end_hit && ((r_reg.loop_pass + 8'h01) < r_reg.loop_total);

   // next-entry decode; codes below minus two other than stop also stop
   always_comb begin
      next_idx = '0;
      next_ok  = 1'b0;
      if (r_reg.ent_next == NEXT_PLUS1) begin
         next_idx = {1'b0, r_reg.cur_idx} + 9'h001;
         next_ok  = (next_idx < 9'(DEPTH));
      end else if (r_reg.ent_next == NEXT_PLUS2) begin
         next_idx = {1'b0, r_reg.cur_idx} + 9'h002;
         next_ok  = (next_idx < 9'(DEPTH));
      end else if (!r_reg.ent_next[NEXT_W-1]) begin
         next_idx = r_reg.ent_next;
         next_ok  = (next_idx < 9'(DEPTH));
      end
   end

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      r_next            = r_reg;
      r_next.move_valid = 1'b0;
      r_next.rd_data    = '0;

      // register writes
      if (wr_i) begin
         unique case (addr_i)
            SEL_ADDR: r_next.entry_sel = wr_data_i[AW-1:0];
            POS_ADDR: r_next.stg_pos   = wr_data_i;
            CFG_ADDR: r_next.stg_cfg   = wr_data_i[CFG_W-1:0];
            OFS_ADDR: r_next.stg_ofs   = wr_data_i[OFS_W-1:0];
            default: ;
         endcase
      end

      // register reads, data only in the following cycle
      if (rd_i) begin
         unique case (addr_i)
            STATUS_ADDR: begin
               r_next.rd_data[ST_BUSY_BIT] = r_reg.busy;
               r_next.rd_data[ST_HOLD_BIT] = (r_reg.state == S_HOLD);
               r_next.rd_data[ST_LOOP_BIT] = r_reg.loop_active;
               r_next.rd_data[ST_ENTRY_LSB +: AW] = r_reg.cur_idx;
               r_next.rd_data[ST_PASS_LSB +: COUNT_W] = r_reg.loop_pass;
            end
            SEL_ADDR: r_next.rd_data[AW-1:0]    = r_reg.entry_sel;
            POS_ADDR: r_next.rd_data            = r_reg.stg_pos;
            CFG_ADDR: r_next.rd_data[CFG_W-1:0] = r_reg.stg_cfg;
            OFS_ADDR: r_next.rd_data[OFS_W-1:0] = r_reg.stg_ofs;
            default:  r_next.rd_data            = '0;
         endcase
      end

      // sequencer
      unique case (r_reg.state)
         S_IDLE: begin
            if (start_req && !stop_req) begin
               r_next.cur_idx = wr_data_i[CTRL_ENTRY_LSB +: AW];
               r_next.state   = S_FETCH;
            end
         end
         S_FETCH: begin
            r_next.state = S_LOAD;
         end
         S_LOAD: begin
            // a count entry opens a loop only while no loop is running
            if (ent_count != COUNT_NONE && !r_reg.loop_active) begin
               r_next.loop_active = 1'b1;
               r_next.loop_start  = r_reg.cur_idx;
               r_next.loop_total  = ent_count;
               r_next.loop_pass   = '0;
            end
            r_next.ent_link   = ent_cfg[CFG_LINK_LSB +: LINK_W];
            r_next.ent_next   = ent_cfg[CFG_NEXT_LSB +: NEXT_W];
            r_next.ent_end    = ent_cfg[CFG_END_BIT];
            // same sum serves coordinate and travel distance
            r_next.move_target = ent_pos + POS_W'(loop_shift);
            r_next.move_incr   = ent_cfg[CFG_INCR_BIT];
            r_next.move_valid  = 1'b1;
            r_next.state       = S_MOVE;
         end
         S_MOVE: begin
            if (move_done_i) begin
               if (r_reg.ent_link == LINK_NONE) begin
                  r_next.state = S_IDLE;
               end else if (rewind) begin
                  r_next.loop_pass = r_reg.loop_pass + 8'h01;
                  r_next.cur_idx   = r_reg.loop_start;
                  r_next.state     = (r_reg.ent_link == LINK_MANUAL) ? S_HOLD : S_FETCH;
               end else begin
                  if (end_hit) begin
                     r_next.loop_active = 1'b0;
                     r_next.loop_pass   = '0;
                  end
                  if (next_ok) begin
                     r_next.cur_idx = next_idx[AW-1:0];
                     r_next.state   = (r_reg.ent_link == LINK_MANUAL) ? S_HOLD : S_FETCH;
                  end else begin
                     r_next.state = S_IDLE;
                  end
               end
            end
         end
         S_HOLD: begin
            if (cont_req) begin
               r_next.state = S_FETCH;
            end
         end
         default: r_next.state = S_IDLE;
      endcase

      // stop from software wins over everything
      if (stop_req) begin
         r_next.state      = S_IDLE;
         r_next.move_valid = 1'b0;
      end

      // leaving the sequence always forgets the loop
      if (r_next.state == S_IDLE) begin
         r_next.loop_active = 1'b0;
         r_next.loop_pass   = '0;
         r_next.loop_total  = '0;
      end
      r_next.busy = (r_next.state != S_IDLE);
   end

   // ---------------------------------------------------------------
   // state register, frozen while the clock enable is low
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r_reg       <= '0;
         r_reg.state <= S_IDLE;
      end else if (ce_i) begin
         r_reg <= r_next;
      end
   end

   assign rd_data_o     = r_reg.rd_data;
   assign move_valid_o  = r_reg.move_valid;
   assign move_target_o = r_reg.move_target;
   assign move_incr_o   = r_reg.move_incr;
   assign move_entry_o  = r_reg.cur_idx;
   assign busy_o        = r_reg.busy;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   logic move_step;
   assign move_step = ce_i && (r_reg.state == S_MOVE) && move_done_i && !stop_req;

   a_load_issues_move: assert property (
      (ce_i && r_reg.state == S_LOAD && !stop_req) |=> (move_valid_o && r_reg.state == S_MOVE))
      else $error("load did not issue a move");

   a_loop_rewinds: assert property (
      (move_step && r_reg.ent_link != LINK_NONE && rewind)
      |=> (r_reg.cur_idx == $past(r_reg.loop_start)
           && r_reg.loop_pass == $past(r_reg.loop_pass) + 8'h01))
      else $error("loop did not rewind to its head");

   a_loop_exit_next: assert property (
      (move_step && r_reg.ent_link == LINK_AUTO && end_hit && !rewind
       && r_reg.ent_next == NEXT_PLUS1 && r_reg.cur_idx < 8'hFF)
      |=> (!r_reg.loop_active && r_reg.cur_idx == $past(r_reg.cur_idx) + 8'h01))
      else $error("loop exit did not follow next field");

   a_no_link_halts: assert property (
      (move_step && r_reg.ent_link == LINK_NONE) |=> (r_reg.state == S_IDLE && !busy_o))
      else $error("no-link entry did not halt");

   a_manual_holds: assert property (
      (r_reg.state == S_HOLD) |-> (r_reg.ent_link == LINK_MANUAL))
      else $error("hold without manual link");

   a_next_stop: assert property (
      (move_step && !rewind && r_reg.ent_next == NEXT_STOP) |=> (r_reg.state == S_IDLE))
      else $error("stop code did not stop");

   a_zero_count: assert property (
      (ce_i && r_reg.state == S_LOAD && !r_reg.loop_active && ent_count == COUNT_NONE
       && !stop_req) |=> !r_reg.loop_active)
      else $error("zero count opened a loop");

   a_first_pass_plain: assert property (
      (ce_i && r_reg.state == S_LOAD && r_reg.loop_pass == 8'h00 && !stop_req)
      |=> (move_target_o == $past(ent_pos)))
      else $error("first pass carried an offset");

   a_no_end_advance: assert property (
      (move_step && r_reg.ent_link == LINK_AUTO && !r_reg.ent_end
       && r_reg.ent_next == NEXT_PLUS1 && r_reg.cur_idx < 8'hFF)
      |=> (r_reg.cur_idx == $past(r_reg.cur_idx) + 8'h01 && r_reg.state == S_FETCH))
      else $error("plain entry did not advance");

   a_offset_grows: assert property (
      (ce_i && r_reg.state == S_LOAD && !stop_req)
      |=> (move_target_o - $past(ent_pos)
           == POS_W'($signed({1'b0, $past(r_reg.loop_pass)}))
              * POS_W'($signed($past(ent_ofs)))))
      else $error("target offset is not pass times offset");

   a_incr_kept: assert property (
      (ce_i && r_reg.state == S_LOAD && !stop_req)
      |=> (move_incr_o == $past(ent_cfg[CFG_INCR_BIT])))
      else $error("incremental flag lost");

   a_idle_no_loop: assert property (
      (r_reg.state == S_IDLE) |-> (!r_reg.loop_active && r_reg.loop_pass == 8'h00))
      else $error("loop state left over in idle");

   c_loop_rewind:   cover property (move_step && r_reg.ent_link != LINK_NONE && rewind);
   c_loop_complete: cover property (move_step && end_hit && !rewind);
   c_manual_hold:   cover property (r_reg.state == S_HOLD ##1 cont_req);
   c_no_link_stop:  cover property (move_step && r_reg.ent_link == LINK_NONE
                                    && r_reg.loop_active);

endmodule

/* File: common/loop_seq_pkg.sv */
// constants, register map and types shared by the loop sequencer files
package loop_seq_pkg;

   // ---------------------------------------------------------------
   // register map, byte addresses of 32-bit words
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] SEL_ADDR    = 8'h08;
   localparam logic [7:0] POS_ADDR    = 8'h0C;
   localparam logic [7:0] CFG_ADDR    = 8'h10;
   localparam logic [7:0] OFS_ADDR    = 8'h14;
   localparam logic [7:0] COMMIT_ADDR = 8'h18;

   // control word bits
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_STOP_BIT  = 1;
   localparam int CTRL_CONT_BIT  = 2;
   localparam int CTRL_ENTRY_LSB = 8;

   // status word bits
   localparam int ST_BUSY_BIT   = 0;
   localparam int ST_HOLD_BIT   = 1;
   localparam int ST_LOOP_BIT   = 2;
   localparam int ST_ENTRY_LSB  = 8;
   localparam int ST_PASS_LSB   = 16;

   // ---------------------------------------------------------------
   // entry field widths and layout of the configuration word
   // ---------------------------------------------------------------
   localparam int POS_W   = 32;
   localparam int OFS_W   = 23;
   localparam int NEXT_W  = 9;
   localparam int COUNT_W = 8;
   localparam int LINK_W  = 2;
   localparam int CFG_W   = 21;
   localparam int CFG_INCR_BIT  = 0;
   localparam int CFG_LINK_LSB  = 1;
   localparam int CFG_END_BIT   = 3;
   localparam int CFG_NEXT_LSB  = 4;
   localparam int CFG_COUNT_LSB = 13;
   localparam int ENTRY_W = POS_W + CFG_W + OFS_W;

   // link modes
   localparam logic [LINK_W-1:0] LINK_NONE   = 2'h0;
   localparam logic [LINK_W-1:0] LINK_MANUAL = 2'h1;
   localparam logic [LINK_W-1:0] LINK_AUTO   = 2'h2;
   localparam logic [LINK_W-1:0] LINK_CONT   = 2'h3;

   // next-entry codes, two's complement in nine bits
   localparam logic [NEXT_W-1:0] NEXT_STOP  = 9'h100;
   localparam logic [NEXT_W-1:0] NEXT_PLUS2 = 9'h1FE;
   localparam logic [NEXT_W-1:0] NEXT_PLUS1 = 9'h1FF;

   localparam logic [COUNT_W-1:0] COUNT_NONE = 8'h00;

   // sequencer states, one-hot
   typedef enum logic [4:0] {
      S_IDLE  = 5'h01,
      S_FETCH = 5'h02,
      S_LOAD  = 5'h04,
      S_MOVE  = 5'h08,
      S_HOLD  = 5'h10
   } seq_state_t;

endpackage

/* File: src/loop_table_mem.sv */
// stored operation entries, one write port and a registered read port
`timescale 1ns/1ps
module loop_table_mem #(
   parameter int WIDTH = 76,
   parameter int DEPTH = 256,
   parameter int AW    = 8
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_b_i,
   input  wire logic             ce_i,
   input  wire logic             wr_en_i,
   input  wire logic [AW-1:0]    wr_addr_i,
   input  wire logic [WIDTH-1:0] wr_data_i,
   input  wire logic             rd_en_i,
   input  wire logic [AW-1:0]    rd_addr_i,
   output logic      [WIDTH-1:0] rd_data_o
);

   // array has no reset; software fills every entry it uses
   logic [WIDTH-1:0] mem [DEPTH];

   // write port
   always_ff @(posedge ref_clk_i) begin
      if (ce_i && wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   // read data from a register, valid the cycle after the enable
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_data_o <= '0;
      end else if (ce_i && rd_en_i) begin
         rd_data_o <= mem[rd_addr_i];
      end
   end

endmodule

/* File: tb/motion_model.sv */
// behavioural motion logic answering move commands with a done pulse
`timescale 1ns/1ps
module motion_model (
   input  wire logic ref_clk_i,
   input  wire logic rst_b_i,
   input  wire logic cmd_valid_i,
   input  wire logic slow_i,
   output logic      done_o
);
   logic [3:0] wait_reg;
   logic       pend_reg;

   // ---------------------------------------------------------------
   // move timing
   // ---------------------------------------------------------------
   // done only ever follows a command; slow mode stretches the move
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         done_o   <= 1'b0;
         pend_reg <= 1'b0;
         wait_reg <= 4'h0;
      end else begin
         done_o <= 1'b0;
         if (cmd_valid_i) begin
            pend_reg <= 1'b1;
            wait_reg <= slow_i ? 4'h6 : 4'h0;
         end else if (pend_reg) begin
            if (wait_reg == 4'h0) begin
               done_o   <= 1'b1;
               pend_reg <= 1'b0;
            end else begin
               wait_reg <= wait_reg - 4'h1;
            end
         end
      end
   end
endmodule

/* File: tb/loop_sequencer_tb.sv */
// self-checking bench for the loop sequencer
`timescale 1ns/1ps
module loop_sequencer_tb;
   import loop_seq_pkg::*;

   logic        ref_clk_i = 1'b0;
   logic        rst_b_i   = 1'b0;
   logic        ce_i      = 1'b1;
   logic [7:0]  addr_i    = 8'h00;
   logic [31:0] wr_data_i = 32'h0;
   logic        wr_i      = 1'b0;
   logic        rd_i      = 1'b0;
   logic        slow      = 1'b0;
   logic [31:0] rd_data_o;
   logic        move_done_i;
   logic        move_valid_o;
   logic [31:0] move_target_o;
   logic        move_incr_o;
   logic [7:0]  move_entry_o;
   logic        busy_o;
   logic [31:0] d;
   int          fail_count  = 0;
   int          checks_done = 0;
   int          cycles      = 0;

   always #2 ref_clk_i = ~ref_clk_i;

   loop_sequencer i_loop_sequencer (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
      .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
      .rd_data_o(rd_data_o), .move_done_i(move_done_i), .move_valid_o(move_valid_o),
      .move_target_o(move_target_o), .move_incr_o(move_incr_o),
      .move_entry_o(move_entry_o), .busy_o(busy_o));

   motion_model i_motion_model (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .cmd_valid_i(move_valid_o), .slow_i(slow), .done_o(move_done_i));

   // ---------------------------------------------------------------
   // bus and check tasks
   // ---------------------------------------------------------------
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk_i);
      addr_i    <= a;
      wr_data_i <= v;
      wr_i      <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1;
      v = rd_data_o;
   endtask

   function automatic logic [31:0] cfg(input logic inc, input logic [1:0] lk,
      input logic endf, input logic [8:0] nxt, input logic [7:0] cnt);
      return {11'h0, cnt, nxt, endf, lk, inc};
   endfunction

   task automatic put(input logic [7:0] e, input logic [31:0] pos, input logic [31:0] c,
      input logic [22:0] ofs);
      wr(SEL_ADDR, {24'h0, e});
      wr(POS_ADDR, pos);
      wr(CFG_ADDR, c);
      wr(OFS_ADDR, {9'h0, ofs});
      wr(COMMIT_ADDR, 32'h0);
   endtask

   task automatic start(input logic [7:0] e);
      wr(CTRL_ADDR, {16'h0, e, 8'h01});
   endtask

   // bounded wait for the next command pulse, then compare it
   task automatic expect_move(input logic [7:0] e, input logic [31:0] t, input logic inc);
      int n;
      n = 0;
      #1;
      while (move_valid_o !== 1'b1 && n < 300) begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      check({31'h0, move_valid_o}, 32'h1);
      check({24'h0, move_entry_o}, {24'h0, e});
      check(move_target_o, t);
      check({31'h0, move_incr_o}, {31'h0, inc});
      @(posedge ref_clk_i);
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      #1;
      while (busy_o !== 1'b0 && n < 300) begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
      check({31'h0, busy_o}, 32'h0);
   endtask

   // entries 0 and 1: three passes, entry 0 shifted 100 steps a pass, then entry 2
   task automatic abs_loop;
      for (int p = 0; p < 3; p++) begin
         expect_move(8'h00, 32'h3E8 + 32'h64 * 32'(p), 1'b0);
         expect_move(8'h01, 32'h64, 1'b0);
      end
      expect_move(8'h02, 32'h7D0, 1'b0);
   endtask

   // ---------------------------------------------------------------
   // hang guard
   // ---------------------------------------------------------------
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 30000) begin
         fail_count++;
         end_sim();
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (16) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      rd(STATUS_ADDR, d);
      check(d, 32'h0);
      check({31'h0, busy_o}, 32'h0);
      // every span entry linked so loops run whole
      put(8'h00, 32'h3E8, cfg(1'b0, LINK_AUTO, 1'b0, NEXT_PLUS1, 8'h03), 23'h64);
      rd(CFG_ADDR, d);
      check(d, cfg(1'b0, LINK_AUTO, 1'b0, NEXT_PLUS1, 8'h03));
      rd(OFS_ADDR, d);
      check(d, 32'h64);
      rd(SEL_ADDR, d);
      check(d, 32'h0);
      rd(8'h1C, d);
      check(d, 32'h0);
      put(8'h01, 32'h64, cfg(1'b0, LINK_AUTO, 1'b1, NEXT_PLUS1, COUNT_NONE), 23'h0);
      put(8'h02, 32'h7D0, cfg(1'b0, LINK_NONE, 1'b0, NEXT_STOP, COUNT_NONE), 23'h0);
      start(8'h00);
      abs_loop();
      wait_idle();
      // incremental span, negative offset, absolute next index
      put(8'h04, 32'h384, cfg(1'b1, LINK_AUTO, 1'b0, NEXT_PLUS1, 8'h03), 23'h64);
      put(8'h05, 32'hFFFFFC7C, cfg(1'b1, LINK_CONT, 1'b1, 9'h007, COUNT_NONE), 23'h7FFF9C);
      put(8'h07, 32'h7D0, cfg(1'b0, LINK_NONE, 1'b0, NEXT_STOP, COUNT_NONE), 23'h0);
      start(8'h04);
      for (int p = 0; p < 3; p++) begin
         expect_move(8'h04, 32'h384 + 32'h64 * 32'(p), 1'b1);
         expect_move(8'h05, 32'hFFFFFC7C - 32'h64 * 32'(p), 1'b1);
      end
      expect_move(8'h07, 32'h7D0, 1'b0);
      wait_idle();
      // skip of two, count zero ignores the offset
      put(8'h08, 32'h10, cfg(1'b0, LINK_AUTO, 1'b0, NEXT_PLUS2, COUNT_NONE), 23'h64);
      put(8'h0A, 32'h20, cfg(1'b0, LINK_NONE, 1'b0, NEXT_STOP, COUNT_NONE), 23'h0);
      start(8'h08);
      expect_move(8'h08, 32'h10, 1'b0);
      expect_move(8'h0A, 32'h20, 1'b0);
      wait_idle();
      // unlinked entry inside a loop halts it; restart begins afresh
      put(8'h0C, 32'h30, cfg(1'b0, LINK_NONE, 1'b0, NEXT_PLUS1, 8'h02), 23'h64);
      for (int k = 0; k < 2; k++) begin
         start(8'h0C);
         expect_move(8'h0C, 32'h30, 1'b0);
         wait_idle();
      end
      // manual link waits for continue
      put(8'h0E, 32'h40, cfg(1'b0, LINK_MANUAL, 1'b0, NEXT_PLUS1, COUNT_NONE), 23'h0);
      put(8'h0F, 32'h50, cfg(1'b0, LINK_NONE, 1'b0, NEXT_STOP, COUNT_NONE), 23'h0);
      start(8'h0E);
      expect_move(8'h0E, 32'h40, 1'b0);
      repeat (20) @(posedge ref_clk_i);
      rd(STATUS_ADDR, d);
      check(d & 32'h3, 32'h3);
      // continue lost while the clock enable is low, hold must remain
      @(posedge ref_clk_i);
      ce_i <= 1'b0;
      wr(CTRL_ADDR, 32'h4);
      ce_i <= 1'b1;
      rd(STATUS_ADDR, d);
      check(d & 32'h3, 32'h3);
      wr(CTRL_ADDR, 32'h4);
      expect_move(8'h0F, 32'h50, 1'b0);
      wait_idle();
      // one-entry loop at the most negative offset
      put(8'h14, 32'h0, cfg(1'b0, LINK_AUTO, 1'b1, NEXT_STOP, 8'h02), 23'h400000);
      start(8'h14);
      expect_move(8'h14, 32'h0, 1'b0);
      expect_move(8'h14, 32'hFFC00000, 1'b0);
      wait_idle();
      // slow moves from here on: stop in the middle of pass one, then a fresh run
      slow <= 1'b1;
      start(8'h00);
      expect_move(8'h00, 32'h3E8, 1'b0);
      expect_move(8'h01, 32'h64, 1'b0);
      expect_move(8'h00, 32'h44C, 1'b0);
      rd(STATUS_ADDR, d);
      check(d & 32'h00FF0007, 32'h00010005);
      wr(CTRL_ADDR, 32'h2);
      wait_idle();
      repeat (12) @(posedge ref_clk_i);
      start(8'h00);
      abs_loop();
      wait_idle();
      end_sim();
   end
endmodule
